// ### include/sbg_pkg.sv
// Package with register offsets, field positions, reset values and gain mode codes of the bias and gain bank.
package sbg_pkg;

    // ------------------------------------------------------------
    // Register offsets on the serial control interface
    // ------------------------------------------------------------
    localparam logic [7:0] SBG_OFS_EXPOSURE_GAIN_A = 8'h10;
    localparam logic [7:0] SBG_OFS_OUTPUT_TRISTATE_CTRL = 8'h12;
    localparam logic [7:0] SBG_OFS_BIAS_CURRENT_SELECT = 8'h13;
    localparam logic [7:0] SBG_OFS_EXPOSURE_GAIN_B = 8'h21;

    // ------------------------------------------------------------
    // Field widths and positions
    // ------------------------------------------------------------
    localparam int SBG_GAIN_W = 6;
    localparam int SBG_BIAS_W = 7;
    localparam int SBG_DATA_W = 8;
    // Tristate control bits.
    localparam int SBG_TS_PIX_BIT = 0;
    localparam int SBG_TS_CTL_BIT = 1;
    // Bias current select bits, one for each analog block.
    localparam int SBG_BIAS_FRAME_RATE_CLAMP_BIT = 0;
    localparam int SBG_BIAS_COLUMN_OFFSET_BIT = 1;
    localparam int SBG_BIAS_WHITE_BALANCE_AMP_BIT = 2;
    localparam int SBG_BIAS_EXPOSURE_AMP_A_BIT = 3;
    localparam int SBG_BIAS_EXPOSURE_AMP_B_BIT = 4;
    localparam int SBG_BIAS_GLOBAL_OFFSET_STAGE_BIT = 5;
    localparam int SBG_BIAS_CONVERTER_BIT = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] SBG_RST_GAIN_CODE = 6'h0e;
    localparam logic [6:0] SBG_RST_BIAS = 7'h00;
    localparam logic SBG_RST_TS_CTL = 1'b1;
    localparam logic SBG_RST_TS_PIX = 1'b1;

    // ------------------------------------------------------------
    // Gain modes and step counts
    // ------------------------------------------------------------
    localparam logic [1:0] SBG_EXP_MODE_RAW = 2'h0;
    localparam logic [1:0] SBG_EXP_MODE_LINEAR = 2'h1;
    localparam int SBG_EXP_MODE_LINEAR2_BIT = 1;
    localparam logic [5:0] SBG_LINEAR_STEPS = 6'h30;
    localparam logic [5:0] SBG_LINEAR_MAX_CODE = 6'h2f;

endpackage

// ### rtl/sbg_gain_decode.sv
// Exposure gain code decoder that maps the two gain codes onto the active gain mode.
`timescale 1ns/1ns
module sbg_gain_decode
    import sbg_pkg::*;
(
    // Mode and raw codes
    input wire logic [1:0] exp_mode,
    input wire logic [sbg_pkg::SBG_GAIN_W-1:0] code_a,
    input wire logic [sbg_pkg::SBG_GAIN_W-1:0] code_b,
    // Decoded step indices and gain B use flag
    output logic [sbg_pkg::SBG_GAIN_W-1:0] index_a,
    output logic [sbg_pkg::SBG_GAIN_W-1:0] index_b,
    output logic b_used
);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------

    // Linear 2 uses code A alone over 64 steps; linear clamps to 48 equal steps; raw passes both codes.
    always_comb
    begin
        index_a = code_a;
        index_b = code_b;
        b_used = 1'b1;
        if (exp_mode[SBG_EXP_MODE_LINEAR2_BIT])
        begin
            index_b = '0;
            b_used = 1'b0;
        end
        else if (exp_mode == SBG_EXP_MODE_LINEAR)
        begin
            if (code_a > SBG_LINEAR_MAX_CODE)
            begin
                index_a = SBG_LINEAR_MAX_CODE;
            end
            if (code_b > SBG_LINEAR_MAX_CODE)
            begin
                index_b = SBG_LINEAR_MAX_CODE;
            end
        end
    end

endmodule // sbg_gain_decode

// ### rtl/sbg_regs.sv
// Bias current, output tristate and exposure gain register bank of the sensor analog chain.
`timescale 1ns/1ns
module sbg_regs
    import sbg_pkg::*;
#(
    parameter int GAIN_W = sbg_pkg::SBG_GAIN_W,
    parameter int BIAS_W = sbg_pkg::SBG_BIAS_W
)
(
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Register port from the serial control interface
    input wire logic [7:0] reg_addr,
    input wire logic [sbg_pkg::SBG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sbg_pkg::SBG_DATA_W-1:0] reg_rdata,
    output logic reg_rdata_valid,
    // Settings held by neighbouring registers
    input wire logic bias_gen_enable,
    input wire logic [1:0] exp_gain_mode,
    input wire logic wb_gain_mode,
    // Bias current selections to the analog blocks
    output logic [sbg_pkg::SBG_BIAS_W-1:0] bias_full,
    // Exposure gain and white balance gain mode to the amplifiers
    output logic [sbg_pkg::SBG_GAIN_W-1:0] gain_code_a,
    output logic [sbg_pkg::SBG_GAIN_W-1:0] gain_code_b,
    output logic gain_b_used,
    output logic wb_linear,
    // Output driver enables
    output logic ctrl_oe,
    output logic pix_oe
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------

    // The field layout is fixed by the register map, so other widths are refused.
    if (GAIN_W != SBG_GAIN_W || BIAS_W != SBG_BIAS_W)
    begin : g_bad_width
        $error("sbg_regs: GAIN_W and BIAS_W must match the register layout");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    typedef struct packed {
        logic [GAIN_W-1:0] gain_a;
        logic [GAIN_W-1:0] gain_b;
        logic [BIAS_W-1:0] bias_sel;
        logic ts_ctl;
        logic ts_pix;
        logic [SBG_DATA_W-1:0] rdata;
        logic rvalid;
        logic [BIAS_W-1:0] bias_eff;
        logic [GAIN_W-1:0] gain_a_eff;
        logic [GAIN_W-1:0] gain_b_eff;
        logic b_used;
        logic wb_lin;
        logic ctrl_oe;
        logic pix_oe;
    } sbg_state_t;

    sbg_state_t state_q;
    sbg_state_t state_d;
    logic [GAIN_W-1:0] dec_index_a;
    logic [GAIN_W-1:0] dec_index_b;
    logic dec_b_used;
    logic hit_gain_a;
    logic hit_gain_b;
    logic hit_tristate;
    logic hit_bias;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // One match line for each mapped register.
    assign hit_gain_a = (reg_addr == SBG_OFS_EXPOSURE_GAIN_A);
    assign hit_gain_b = (reg_addr == SBG_OFS_EXPOSURE_GAIN_B);
    assign hit_tristate = (reg_addr == SBG_OFS_OUTPUT_TRISTATE_CTRL);
    assign hit_bias = (reg_addr == SBG_OFS_BIAS_CURRENT_SELECT);

    // ------------------------------------------------------------
    // Gain mode decode
    // ------------------------------------------------------------

    // Maps the stored codes onto the step indices of the active exposure mode.
    sbg_gain_decode u_gain_decode
    (
        .exp_mode(exp_gain_mode),
        .code_a(state_q.gain_a),
        .code_b(state_q.gain_b),
        .index_a(dec_index_a),
        .index_b(dec_index_b),
        .b_used(dec_b_used)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Register writes, read data and the registered outputs to the analog chain.
    always_comb
    begin
        state_d = state_q;
        state_d.rvalid = 1'b0;

        // Writes land in the stored fields; the upper bits of each byte are dropped.
        if (reg_wr)
        begin
            if (hit_gain_a)
            begin
                state_d.gain_a = reg_wdata[GAIN_W-1:0];
            end
            if (hit_gain_b)
            begin
                state_d.gain_b = reg_wdata[GAIN_W-1:0];
            end
            if (hit_tristate)
            begin
                state_d.ts_ctl = reg_wdata[SBG_TS_CTL_BIT];
                state_d.ts_pix = reg_wdata[SBG_TS_PIX_BIT];
            end
            if (hit_bias)
            begin
                state_d.bias_sel = reg_wdata[BIAS_W-1:0];
            end
        end

        // Reads return the stored fields one cycle later, with zeros in the unused bits.
        if (reg_rd)
        begin
            state_d.rvalid = 1'b1;
            state_d.rdata = '0;
            if (hit_gain_a)
            begin
                state_d.rdata[GAIN_W-1:0] = state_q.gain_a;
            end
            else if (hit_gain_b)
            begin
                state_d.rdata[GAIN_W-1:0] = state_q.gain_b;
            end
            else if (hit_tristate)
            begin
                state_d.rdata[SBG_TS_CTL_BIT] = state_q.ts_ctl;
                state_d.rdata[SBG_TS_PIX_BIT] = state_q.ts_pix;
            end
            else if (hit_bias)
            begin
                state_d.rdata[BIAS_W-1:0] = state_q.bias_sel;
            end
        end

        if (bias_gen_enable)
        begin
            state_d.bias_eff = state_q.bias_sel;
        end
        else
        begin
            state_d.bias_eff = SBG_RST_BIAS;
        end

        // A and B in raw, linear
        state_d.gain_a_eff = dec_index_a;
        state_d.gain_b_eff = dec_index_b;
        state_d.b_used = dec_b_used;
        state_d.wb_lin = wb_gain_mode;

        state_d.ctrl_oe = state_q.ts_ctl;
        state_d.pix_oe = state_q.ts_pix;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Synchronous reset, which wins over the clock enable; without reset, the clock enable freezes everything while low.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q.gain_a <= SBG_RST_GAIN_CODE;
            state_q.gain_b <= SBG_RST_GAIN_CODE;
            state_q.bias_sel <= SBG_RST_BIAS;
            state_q.ts_ctl <= SBG_RST_TS_CTL;
            state_q.ts_pix <= SBG_RST_TS_PIX;
            state_q.rdata <= '0;
            state_q.rvalid <= 1'b0;
            state_q.bias_eff <= SBG_RST_BIAS;
            state_q.gain_a_eff <= SBG_RST_GAIN_CODE;
            state_q.gain_b_eff <= SBG_RST_GAIN_CODE;
            state_q.b_used <= 1'b1;
            state_q.wb_lin <= 1'b0;
            state_q.ctrl_oe <= SBG_RST_TS_CTL;
            state_q.pix_oe <= SBG_RST_TS_PIX;
        end
        else if (ce)
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Every output is a field of the state register.
    assign reg_rdata = state_q.rdata;
    assign reg_rdata_valid = state_q.rvalid;
    assign bias_full = state_q.bias_eff;
    assign gain_code_a = state_q.gain_a_eff;
    assign gain_code_b = state_q.gain_b_eff;
    assign gain_b_used = state_q.b_used;
    assign wb_linear = state_q.wb_lin;
    assign ctrl_oe = state_q.ctrl_oe;
    assign pix_oe = state_q.pix_oe;

endmodule // sbg_regs

// ### verif/sbg_regs_props.sv
// Concurrent port checks for the bias, tristate and exposure gain register bank.
`timescale 1ns/1ns
module sbg_regs_props
    import sbg_pkg::*;
(
    // Clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid,
    // Settings and controlled outputs
    input wire logic bias_gen_enable,
    input wire logic [1:0] exp_gain_mode,
    input wire logic wb_gain_mode,
    input wire logic [6:0] bias_full,
    input wire logic [5:0] gain_code_a,
    input wire logic [5:0] gain_code_b,
    input wire logic gain_b_used,
    input wire logic wb_linear,
    input wire logic ctrl_oe,
    input wire logic pix_oe
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic ok_q;
    // Marks that the previous edge was a live, enabled one, so reset values never count.
    always_ff @(posedge clk) ok_q <= ce && !reset;
    a_bias_gate_off: assert property (ok_q && !$past(bias_gen_enable) |-> bias_full == 7'h00)
        else $error("bias selection active while generator disabled");
    a_bias_map_write: assert property (ce && reg_wr && reg_addr == 8'h13 && bias_gen_enable ##1 ce && bias_gen_enable
        |=> bias_full == $past(reg_wdata[6:0], 2))
        else $error("bias selection does not follow written value");
    a_oe_follow: assert property (ce && reg_wr && reg_addr == 8'h12 ##1 ce
        |=> {ctrl_oe, pix_oe} == $past(reg_wdata[1:0], 2))
        else $error("driver enables do not follow tristate value");
    a_gain_raw_a: assert property (ce && reg_wr && reg_addr == 8'h10 && exp_gain_mode == 2'h0 ##1 ce && exp_gain_mode == 2'h0
        |=> gain_code_a == $past(reg_wdata[5:0], 2))
        else $error("raw gain code A does not follow written value");
    a_linear_clamp: assert property (ok_q && $past(exp_gain_mode) == 2'h1
        |-> gain_code_a <= 6'h2f && gain_code_b <= 6'h2f)
        else $error("linear gain index beyond last usable step");
    a_gain_b_ignored: assert property (ok_q && $past(exp_gain_mode[1]) |-> gain_code_b == 6'h00)
        else $error("gain B index not cleared in linear 2 mode");
    a_gain_b_flag: assert property (ok_q |-> gain_b_used == !$past(exp_gain_mode[1]))
        else $error("gain B use flag wrong for mode");
    a_read_pulse: assert property (ok_q |-> reg_rdata_valid == $past(reg_rd))
        else $error("read valid not one cycle after read strobe");
    a_unmapped_zero: assert property (ce && reg_rd && !(reg_addr inside {8'h10, 8'h12, 8'h13, 8'h21})
        |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero data");
    // Main scenarios reached.
    c_bias_on: cover property (ce && reg_wr && reg_addr == 8'h13 && bias_gen_enable);
    c_lin_top: cover property (exp_gain_mode == 2'h1 && gain_code_a == 6'h2f);
    c_lin2_read: cover property (reg_rdata_valid && !gain_b_used);
endmodule // sbg_regs_props

bind sbg_regs sbg_regs_props u_props (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .bias_gen_enable(bias_gen_enable), .exp_gain_mode(exp_gain_mode), .wb_gain_mode(wb_gain_mode),
    .bias_full(bias_full), .gain_code_a(gain_code_a), .gain_code_b(gain_code_b), .gain_b_used(gain_b_used),
    .wb_linear(wb_linear), .ctrl_oe(ctrl_oe), .pix_oe(pix_oe));

// ### verif/sbg_regs_tb.sv
// Self-checking bench for the bias, tristate and exposure gain register bank.
`timescale 1ns/1ns
module sbg_regs_tb;
    import sbg_pkg::*;
    `define SBG_CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin n_fail++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn); end end
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic bias_gen_enable = 1'b0, wb_gain_mode = 1'b0;
    logic [1:0] exp_gain_mode = 2'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ga, gb, seen;
    logic reg_rdata_valid, gain_b_used, wb_linear, ctrl_oe, pix_oe;
    logic [6:0] bias_full;
    logic [5:0] gain_code_a, gain_code_b, ea, eb;
    logic [7:0] exp_q[$];
    integer seed = 32'h18c5;
    int n_fail = 0, checks_done = 0;
    // Clock of 100 ns period.
    initial forever #50 clk = ~clk;
    sbg_regs dut (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .bias_gen_enable(bias_gen_enable),
        .exp_gain_mode(exp_gain_mode), .wb_gain_mode(wb_gain_mode), .bias_full(bias_full),
        .gain_code_a(gain_code_a), .gain_code_b(gain_code_b), .gain_b_used(gain_b_used), .wb_linear(wb_linear),
        .ctrl_oe(ctrl_oe), .pix_oe(pix_oe));
    // ------------------------------------------------------------
    // Register port tasks
    // ------------------------------------------------------------
    // Issues a one-cycle write strobe with address and data.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // Issues a read and notes the value that must come back.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        reg_rd = 1'b0;
    endtask
    // Checks the state that every reset leaves behind.
    task automatic chk_rst;
        `SBG_CHK("bias_full", 7'h00, bias_full)
        `SBG_CHK("gain codes", 12'h38e, {gain_code_a, gain_code_b})
        `SBG_CHK("output enables", 2'h3, {ctrl_oe, pix_oe})
        rd(8'h10, 8'h0e);
        rd(8'h12, 8'h03);
        rd(8'h13, 8'h00);
        rd(8'h21, 8'h0e);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        `SBG_CHK("pending reads", 0, exp_q.size())
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Compares read data against the oldest noted value.
    always @(negedge clk)
        if (reg_rdata_valid === 1'b1)
        begin
            seen = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `SBG_CHK("reg_rdata", seen, reg_rdata)
        end
    // Cuts a hung run short.
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        chk_rst();
        wr(8'h13, 8'hff);
        @(negedge clk);
        `SBG_CHK("bias_full", 7'h00, bias_full)
        rd(8'h13, 8'h7f);
        bias_gen_enable = 1'b1;
        @(negedge clk);
        `SBG_CHK("bias_full", 7'h7f, bias_full)
        for (int i = 0; i < 9; i++)
        begin
            ga = (i < 7) ? (8'h01 << i) : 8'($random(seed));
            wr(8'h13, ga);
            @(negedge clk);
            `SBG_CHK("bias_full", ga[6:0], bias_full)
        end
        for (int v = 0; v < 4; v++)
        begin
            wr(8'h12, 8'hfc | 8'(v));
            @(negedge clk);
            `SBG_CHK("output enables", v[1:0], {ctrl_oe, pix_oe})
            rd(8'h12, 8'(v));
        end
        // Every exposure mode code, with a random pair and the linear boundary pair.
        for (int m = 0; m < 8; m++)
        begin
            exp_gain_mode = m[2:1];
            ga = m[0] ? 8'hef : 8'($random(seed));
            gb = m[0] ? 8'hf0 : 8'($random(seed));
            wr(8'h10, ga);
            wr(8'h21, gb);
            @(negedge clk);
            ea = (m[2:1] == 2'h1 && ga[5:0] > 6'h2f) ? 6'h2f : ga[5:0];
            eb = (m[2:1] == 2'h1 && gb[5:0] > 6'h2f) ? 6'h2f : gb[5:0];
            eb = m[2] ? 6'h00 : eb;
            `SBG_CHK("gain_code_a", ea, gain_code_a)
            `SBG_CHK("gain_code_b", eb, gain_code_b)
            `SBG_CHK("gain_b_used", !m[2], gain_b_used)
            rd(8'h21, {2'b00, gb[5:0]});
        end
        for (int w = 1; w >= 0; w--)
        begin
            wb_gain_mode = w[0];
            @(negedge clk);
            `SBG_CHK("wb_linear", w[0], wb_linear)
        end
        ce = 1'b0;
        wr(8'h10, 8'h3f);
        ce = 1'b1;
        rd(8'h10, 8'h2f);
        wr(8'h11, 8'h55);
        rd(8'h11, 8'h00);
        rd(8'hff, 8'h00);
        exp_gain_mode = 2'h0;
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        chk_rst();
        @(negedge clk);
        wrap_up();
    end
endmodule // sbg_regs_tb
